// [core/ecs_pkg.sv]
package ecs_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] OFS_CMD = 8'hB0;
  localparam logic [7:0] OFS_DATA = 8'hB4;
  localparam logic [7:0] OFS_ISTAT = 8'hB8;
  localparam logic [7:0] OFS_IMASK = 8'hBC;
  // ==========================================================
  // command register fields
  localparam int BUSY_BIT = 31;
  localparam int CMD_HI = 30;
  localparam int CMD_LO = 28;
  localparam int TMO_BIT = 9;
  localparam int LOADED_BIT = 8;
  localparam int ADDR_W = 7;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TMO = 1;
  localparam int IRQ_W = 2;
  // ==========================================================
  // commands
  typedef enum logic [2:0] {
    CMD_READ = 3'h0, CMD_WR_DIS = 3'h1, CMD_WR_EN = 3'h2, CMD_WRITE = 3'h3,
    CMD_WRAL = 3'h4, CMD_ERASE = 3'h5, CMD_ERAL = 3'h6, CMD_RELOAD = 3'h7
  } ecs_cmd_t;
  // serial opcodes and address extensions
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_ER = 2'h3;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [6:0] EXT_WR_DIS = 7'h00;
  localparam logic [6:0] EXT_WRAL = 7'h20;
  localparam logic [6:0] EXT_ERAL = 7'h40;
  localparam logic [6:0] EXT_WR_EN = 7'h60;
  localparam logic [4:0] BITS_SHORT = 5'h0A;
  localparam logic [4:0] BITS_LONG = 5'h12;
  // reload signature and length
  localparam logic [7:0] SIGNATURE = 8'hA5;
  localparam logic [2:0] MAC_BYTES = 3'h6;
  // ==========================================================
  // timing
  localparam int CLK_KHZ = 125000;
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
  // ==========================================================
  // serial pins driven toward the memory
  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } ecs_pins_t;
endpackage : ecs_pkg

// [core/ecs_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
module ecs_sequencer #(
  parameter int TIMEOUT_CYC = ecs_pkg::TIMEOUT_CYC,
  parameter int SK_HALF = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial memory pins
  output ecs_pkg::ecs_pins_t eeprom_pins,
  input wire logic eeprom_do,
  // results
  output logic [47:0] mac_addr,
  output logic irq
);
  // ==========================================================
  // state
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_SHIFT = 5'b00010, ST_GAP = 5'b00100,
    ST_WAIT = 5'b01000, ST_END = 5'b10000
  } ecs_state_t;

  ecs_state_t state_ff, nxt_state;
  logic busy_ff, tmo_ff, loaded_ff;
  ecs_pkg::ecs_cmd_t cmd_ff;
  logic [ecs_pkg::ADDR_W-1:0] addr_ff;
  logic [7:0] data_ff;
  logic [ecs_pkg::IRQ_W-1:0] istat_ff, imask_ff;
  logic [47:0] mac_ff;
  logic [2:0] idx_ff;
  logic [17:0] tx_ff;
  logic [7:0] rx_ff;
  logic [4:0] bits_ff;
  logic [15:0] div_ff;
  logic [21:0] tmo_cnt_ff;
  logic do_meta_ff, do_sync_ff;
  ecs_pkg::ecs_pins_t pins_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, irq_ff;

  // ==========================================================
  // frame builder
  function automatic logic [17:0] frame(input ecs_pkg::ecs_cmd_t c,
      input logic [6:0] a, input logic [7:0] d);
    logic [1:0] op;
    logic [6:0] ad;
    op = ecs_pkg::OP_EXT;
    ad = a;
    unique case (c)
      ecs_pkg::CMD_READ, ecs_pkg::CMD_RELOAD: op = ecs_pkg::OP_RD;
      ecs_pkg::CMD_WR_DIS: ad = ecs_pkg::EXT_WR_DIS;
      ecs_pkg::CMD_WR_EN: ad = ecs_pkg::EXT_WR_EN;
      ecs_pkg::CMD_WRITE: op = ecs_pkg::OP_WR;
      ecs_pkg::CMD_WRAL: ad = ecs_pkg::EXT_WRAL;
      ecs_pkg::CMD_ERASE: op = ecs_pkg::OP_ER;
      ecs_pkg::CMD_ERAL: ad = ecs_pkg::EXT_ERAL;
    endcase
    return {1'b1, op, ad, d};
  endfunction : frame

  function automatic logic [4:0] frame_bits(input ecs_pkg::ecs_cmd_t c);
    logic long;
    long = (c == ecs_pkg::CMD_READ) || (c == ecs_pkg::CMD_RELOAD) ||
           (c == ecs_pkg::CMD_WRITE) || (c == ecs_pkg::CMD_WRAL);
    return long ? ecs_pkg::BITS_LONG : ecs_pkg::BITS_SHORT;
  endfunction : frame_bits

  // ==========================================================
  // apb decode
  wire acc = psel && penable && !pready_ff;
  wire wr_done = psel && penable && pwrite && pready_ff;
  wire hit_cmd = paddr == ecs_pkg::OFS_CMD;
  wire hit_data = paddr == ecs_pkg::OFS_DATA;
  wire hit_istat = paddr == ecs_pkg::OFS_ISTAT;
  wire hit_imask = paddr == ecs_pkg::OFS_IMASK;
  wire mapped = hit_cmd || hit_data || hit_istat || hit_imask;
  wire wr_cmd = wr_done && hit_cmd;
  // a new command is only accepted while idle; a command write during busy can only clear the timeout flag
  wire start_host = wr_cmd && !busy_ff && pwdata[ecs_pkg::BUSY_BIT];
  wire [31:0] cmd_rd = {busy_ff, cmd_ff, 18'h00000, tmo_ff, loaded_ff,
                        1'b0, addr_ff};
  wire [31:0] rd_mux = hit_cmd ? cmd_rd :
                       hit_data ? {24'h000000, data_ff} :
                       hit_istat ? {30'h00000000, istat_ff} :
                       hit_imask ? {30'h00000000, imask_ff} : 32'h00000000;

  // ==========================================================
  // sequencer
  wire half_end = div_ff == 16'(SK_HALF - 1);
  wire bit_end = half_end && pins_ff.sk;
  wire last_bit = bit_end && bits_ff == 5'h01;
  wire timed_out = !state_ff[0] && tmo_cnt_ff == 22'(TIMEOUT_CYC - 1);
  wire is_rd = cmd_ff == ecs_pkg::CMD_READ || cmd_ff == ecs_pkg::CMD_RELOAD;
  wire needs_rdy = !is_rd && cmd_ff != ecs_pkg::CMD_WR_DIS &&
                   cmd_ff != ecs_pkg::CMD_WR_EN;
  wire [7:0] rx_byte = {rx_ff[6:0], do_sync_ff};
  wire reload = cmd_ff == ecs_pkg::CMD_RELOAD;
  wire sig_bad = reload && idx_ff == 3'h0 && rx_ff != ecs_pkg::SIGNATURE;
  wire more = reload && !sig_bad && idx_ff != ecs_pkg::MAC_BYTES;
  wire finish = state_ff == ST_END && !more;
  wire ev_done = finish || timed_out;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (start_host) nxt_state = ST_SHIFT;
      ST_SHIFT: if (last_bit) nxt_state = needs_rdy ? ST_GAP : ST_END;
      ST_GAP: if (half_end) nxt_state = ST_WAIT;
      // a write with nothing attached stays here until the timer fires
      ST_WAIT: if (do_sync_ff) nxt_state = ST_END;
      ST_END: nxt_state = more ? ST_SHIFT : ST_IDLE;
    endcase
    if (timed_out) nxt_state = ST_IDLE;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_END;
      busy_ff <= 1'b1;
      cmd_ff <= ecs_pkg::CMD_RELOAD;
      idx_ff <= 3'h7;
      tmo_ff <= 1'b0;
      loaded_ff <= 1'b0;
      addr_ff <= '0;
      data_ff <= 8'h00;
      istat_ff <= '0;
      imask_ff <= '0;
      mac_ff <= 48'h000000000000;
      tx_ff <= 18'h00000;
      rx_ff <= 8'h00;
      bits_ff <= 5'h00;
      div_ff <= 16'h0000;
      tmo_cnt_ff <= 22'h000000;
      do_meta_ff <= 1'b0;
      do_sync_ff <= 1'b0;
      pins_ff <= '0;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      do_meta_ff <= eeprom_do;
      do_sync_ff <= do_meta_ff;
      state_ff <= nxt_state;
      pready_ff <= acc;
      pslverr_ff <= acc && !mapped;
      if (acc) prdata_ff <= rd_mux;
      irq_ff <= |(istat_ff & imask_ff);
      // host fields
      if (start_host) begin
        cmd_ff <= ecs_pkg::ecs_cmd_t'(pwdata[ecs_pkg::CMD_HI:ecs_pkg::CMD_LO]);
        addr_ff <= pwdata[ecs_pkg::ADDR_W-1:0];
        idx_ff <= 3'h0;
        if (pwdata[ecs_pkg::CMD_HI:ecs_pkg::CMD_LO] == ecs_pkg::CMD_RELOAD)
          loaded_ff <= 1'b0;
      end
      if (wr_done && hit_data && !busy_ff) data_ff <= pwdata[7:0];
      if (wr_done && hit_imask) imask_ff <= pwdata[ecs_pkg::IRQ_W-1:0];
      // sticky flags: a fresh set wins over a same-cycle clear
      if (timed_out) tmo_ff <= 1'b1;
      else if (wr_cmd && pwdata[ecs_pkg::TMO_BIT]) tmo_ff <= 1'b0;
      istat_ff <= (istat_ff &
                   ~((wr_done && hit_istat) ? pwdata[ecs_pkg::IRQ_W-1:0] : '0))
                  | {timed_out, ev_done};
      // busy held from start to the end of the run
      if (start_host) busy_ff <= 1'b1;
      else if (ev_done) busy_ff <= 1'b0;
      // timeout counter restarts with every new run
      tmo_cnt_ff <= (state_ff == ST_IDLE) ? 22'h000000
                    : tmo_cnt_ff + 22'h000001;
      // clock divider
      div_ff <= (half_end || state_ff == ST_IDLE || state_ff == ST_END)
                ? 16'h0000 : div_ff + 16'h0001;
      unique case (state_ff)
        ST_IDLE: pins_ff <= '0;
        ST_END: begin
          pins_ff <= '0;
          if (is_rd) data_ff <= rx_ff;
          if (reload && idx_ff != 3'h0 && !sig_bad)
            mac_ff <= {rx_ff, mac_ff[47:8]};
          if (reload && idx_ff == ecs_pkg::MAC_BYTES) loaded_ff <= 1'b1;
          if (more) begin
            idx_ff <= idx_ff + 3'h1;
            tx_ff <= frame(cmd_ff, {4'h0, idx_ff + 3'h1}, data_ff);
            bits_ff <= frame_bits(cmd_ff);
          end
        end
        ST_SHIFT: begin
          pins_ff.cs <= 1'b1;
          pins_ff.di <= tx_ff[17];
          if (half_end) pins_ff.sk <= !pins_ff.sk;
          // memory sees di on the rising edge; its output read at the fall
          if (bit_end) begin
            tx_ff <= {tx_ff[16:0], 1'b0};
            rx_ff <= rx_byte;
            bits_ff <= bits_ff - 5'h01;
          end
        end
        ST_GAP: pins_ff <= '0;
        ST_WAIT: pins_ff.cs <= 1'b1;
      endcase
      if (start_host) begin
        tx_ff <= frame(
          ecs_pkg::ecs_cmd_t'(pwdata[ecs_pkg::CMD_HI:ecs_pkg::CMD_LO]),
          pwdata[ecs_pkg::ADDR_W-1:0], data_ff);
        bits_ff <= frame_bits(
          ecs_pkg::ecs_cmd_t'(pwdata[ecs_pkg::CMD_HI:ecs_pkg::CMD_LO]));
      end
      if (timed_out) pins_ff <= '0;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign eeprom_pins = pins_ff;
  assign mac_addr = mac_ff;
  assign irq = irq_ff;
endmodule : ecs_sequencer
`default_nettype wire

// [verification/ecs_props.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// port checker
module ecs_props #(
  parameter int TIMEOUT_CYC = 2000
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // serial pins
  input wire ecs_pkg::ecs_pins_t eeprom_pins
);
  logic [2:0] code_ff;
  logic [6:0] adr_ff;
  logic [4:0] cnt_ff = 5'h00;
  logic [9:0] hdr_ff;
  logic sk_ff;
  int run_ff = 0;
  wire logic go = psel && penable && pready && pwrite
    && paddr == ecs_pkg::OFS_CMD && pwdata[31];
  wire logic [1:0] op_exp = (code_ff == 3'h0 || code_ff == 3'h7)
    ? ecs_pkg::OP_RD : code_ff == 3'h3 ? ecs_pkg::OP_WR
    : code_ff == 3'h5 ? ecs_pkg::OP_ER : ecs_pkg::OP_EXT;
  wire logic [6:0] ext_exp = code_ff[0] ? ecs_pkg::EXT_WR_DIS
    : ecs_pkg::EXT_WR_EN;
  // bit count restarts with every chip select, so each frame is judged alone
  always_ff @(posedge clk) begin
    sk_ff <= eeprom_pins.sk;
    run_ff <= eeprom_pins.cs ? run_ff + 1 : 0;
    if (go) begin
      code_ff <= pwdata[30:28];
      adr_ff <= pwdata[6:0];
    end
    if (srst) code_ff <= 3'h7;
    if (!eeprom_pins.cs) cnt_ff <= 5'h00;
    else if (eeprom_pins.sk && !sk_ff) begin
      cnt_ff <= cnt_ff + 5'h01;
      hdr_ff <= {hdr_ff[8:0], eeprom_pins.di};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_open;
    $rose(eeprom_pins.cs) && eeprom_pins.di;
  endsequence
  chk_reset_reload:
    assert property ($fell(srst) |-> ##[0:8] s_open)
    else $error("no reload frame after reset");
  chk_cmd_start:
    assert property (go |-> ##[1:4] s_open)
    else $error("command write opened no frame");
  chk_busy_frame:
    assert property (pready && !pwrite && paddr == ecs_pkg::OFS_CMD
      && eeprom_pins.cs |-> prdata[31])
    else $error("busy low while a frame runs");
  chk_op_code:
    assert property (cnt_ff == 5'h03 |-> hdr_ff[2:0] == {1'b1, op_exp})
    else $error("wrong start or opcode bits");
  chk_ext_code:
    assert property (cnt_ff == 5'h0A && code_ff inside {3'h1, 3'h2}
      |-> hdr_ff[6:0] == ext_exp)
    else $error("wrong enable or disable code");
  chk_read_addr:
    assert property (cnt_ff == 5'h0A && code_ff == 3'h0
      |-> hdr_ff[6:0] == adr_ff)
    else $error("read frame carries wrong address");
  chk_run_bound:
    assert property (eeprom_pins.cs |-> run_ff < TIMEOUT_CYC + 8)
    else $error("operation outlived the timeout");
  chk_apb_answer:
    assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered in one cycle");
endmodule : ecs_props
bind ecs_sequencer ecs_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
  .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .eeprom_pins);
`default_nettype wire

// [verification/ecs_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// three-wire serial memory, data out pulled down when released
module ecs_mem_model (
  // clock
  input wire logic clk,
  // pins
  input wire ecs_pkg::ecs_pins_t pins,
  input wire logic present,
  input wire logic [7:0] prog_cyc,
  output logic data_out
);
  logic [7:0] mem [128];
  logic [17:0] sr_ff;
  logic [1:0] op_ff;
  logic [6:0] ad_ff;
  logic en_ff = 1'b0, sk_ff = 1'b0, cs_ff = 1'b0, rdy_ff = 1'b0;
  int cnt_ff = 0, bsy_ff = 0;
  wire logic wr_end = cnt_ff == 18 && sr_ff[16:15] == ecs_pkg::OP_WR;
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'h3C ^ 8'(i);
    mem[0] = 8'hA5;
    data_out = 1'b0;
  end
  always @(posedge clk) begin
    sk_ff <= pins.sk;
    cs_ff <= pins.cs;
    if (bsy_ff > 0) bsy_ff <= bsy_ff - 1;
    if (!pins.cs) cnt_ff <= 0;
    else if (pins.sk && !sk_ff) begin
      sr_ff <= {sr_ff[16:0], pins.di};
      cnt_ff <= cnt_ff + 1;
    end
    if (pins.cs && cnt_ff == 10) begin
      op_ff <= sr_ff[8:7];
      ad_ff <= sr_ff[6:0];
    end
    // program cycle only when enabled; disabled writes still report ready
    if (cs_ff && !pins.cs) begin
      rdy_ff <= wr_end;
      if (present && en_ff && wr_end) begin
        mem[sr_ff[14:8]] <= sr_ff[7:0];
        bsy_ff <= int'(prog_cyc);
      end
      if (present && cnt_ff == 10 && sr_ff[8:7] == ecs_pkg::OP_EXT
        && sr_ff[5] == sr_ff[6]) en_ff <= sr_ff[6];
    end
    if (!present || !pins.cs) data_out <= 1'b0;
    else if (rdy_ff) data_out <= (bsy_ff == 0);
    else if (sk_ff && !pins.sk && cnt_ff >= 10 && cnt_ff < 18
      && op_ff == ecs_pkg::OP_RD) data_out <= mem[ad_ff][17 - cnt_ff];
  end
endmodule : ecs_mem_model
`default_nettype wire

// [verification/ecs_sequencer_tb.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bench for the command sequencer
module ecs_sequencer_tb;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, present = 1'b1, pready, pslverr, irq, mem_do;
  logic ce = 1'b1;
  ecs_pkg::ecs_pins_t frozen;
  logic [7:0] paddr = 8'h00, prog = 8'h28, rnd;
  logic [6:0] ra;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [47:0] mac_addr, mac_exp;
  logic [64:0] exp_q[$], note;
  ecs_pkg::ecs_pins_t pins;
  int fail_count = 0, n_compared = 0;
  always #4 clk = ~clk;
  ecs_sequencer #(.TIMEOUT_CYC(2000), .SK_HALF(4)) dut (.clk, .srst,
    .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .eeprom_pins(pins), .eeprom_do(mem_do), .mac_addr, .irq);
  ecs_mem_model u_mem (.clk, .pins, .present, .prog_cyc(prog),
    .data_out(mem_do));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [64:0] nt);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(nt);
    @(posedge clk);
    penable <= 1'b1;
    // pready is judged as it stands at the rising edge, request held till then
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [32:0] v);
    apb(1'b0, a, 32'h0, {v[32], m, v[31:0]});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 65'h0);
  endtask : wr
  task automatic cmd(input logic [2:0] c, input logic [6:0] a);
    wr(ecs_pkg::OFS_CMD, {1'b1, c, 21'h0, a});
    do rd(ecs_pkg::OFS_CMD, 32'h0, 33'h0); while (q[31] !== 1'b0);
  endtask : cmd
  task automatic irq_is(input logic v);
    repeat (2) @(negedge clk);
    check({63'h0, irq}, {63'h0, v});
  endtask : irq_is
  // a zero mask marks a poll whose value is not judged
  always @(negedge clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[63:32] != 32'h0) check({31'h0, pslverr,
        prdata & note[63:32]}, {31'h0, note[64], note[31:0]});
    end
  end
  initial begin
    void'($urandom(32'h4F51));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(ecs_pkg::OFS_CMD, 32'h8000_0000, 33'h0_8000_0000);
    // clock enable low must freeze the running reload frame on the pins
    ce <= 1'b0;
    @(posedge clk);
    frozen = pins;
    repeat (6) begin
      @(posedge clk);
      check({61'h0, pins}, {61'h0, frozen});
    end
    ce <= 1'b1;
    do rd(ecs_pkg::OFS_CMD, 32'h0, 33'h0); while (q[31] !== 1'b0);
    for (int i = 1; i < 7; i++) mac_exp[8*(i-1) +: 8] = 8'h3C ^ 8'(i);
    check({16'h0, mac_addr}, {16'h0, mac_exp});
    rd(ecs_pkg::OFS_CMD, 32'h8000_0100, 33'h0_0000_0100);
    rd(8'h40, 32'hFFFF_FFFF, 33'h1_0000_0000);
    wr(ecs_pkg::OFS_IMASK, 32'h3);
    rnd = 8'($urandom);
    ra = 7'h10 + 7'($urandom_range(0, 99));
    wr(ecs_pkg::OFS_DATA, {24'h0, rnd});
    cmd(3'h1, 7'h00);
    cmd(3'h3, ra);
    cmd(3'h0, ra);
    rd(ecs_pkg::OFS_DATA, 32'hFF, {25'h0, 8'h3C ^ {1'b0, ra}});
    cmd(3'h2, 7'h00);
    wr(ecs_pkg::OFS_DATA, {24'h0, rnd});
    cmd(3'h3, ra);
    cmd(3'h0, ra);
    rd(ecs_pkg::OFS_DATA, 32'hFF, {25'h0, rnd});
    irq_is(1'b1);
    rd(ecs_pkg::OFS_ISTAT, 32'h3, 33'h1);
    wr(ecs_pkg::OFS_ISTAT, 32'h3);
    irq_is(1'b0);
    wr(ecs_pkg::OFS_IMASK, 32'h0);
    present <= 1'b0;
    cmd(3'h3, 7'h20);
    rd(ecs_pkg::OFS_CMD, 32'h8000_0200, 33'h0_0000_0200);
    irq_is(1'b0);
    rd(ecs_pkg::OFS_ISTAT, 32'h3, 33'h3);
    wr(ecs_pkg::OFS_IMASK, 32'h2);
    irq_is(1'b1);
    wr(ecs_pkg::OFS_CMD, 32'h0000_0200);
    wr(ecs_pkg::OFS_ISTAT, 32'h3);
    rd(ecs_pkg::OFS_CMD, 32'h0000_0200, 33'h0);
    cmd(3'h7, 7'h00);
    present <= 1'b1;
    cmd(3'h7, 7'h00);
    rd(ecs_pkg::OFS_CMD, 32'h8000_0100, 33'h0_0000_0100);
    end_of_test();
  end
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end
endmodule : ecs_sequencer_tb
`default_nettype wire
